// [include/icbp_pkg.sv]
// Purpose: shared constants for the instruction cache control and branch predictor
// Assumes: 32-way sets, 32-byte lines, word-wide classic Wishbone register port
// Notes: command and control registers sit at word-aligned byte offsets
package icbp_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ICBP_REG_CONTROL = 8'h00;
  localparam logic [7:0] ICBP_REG_CACHE_FN = 8'h04;
  localparam logic [7:0] ICBP_REG_LOCK_FN = 8'h08;
  localparam logic [7:0] ICBP_REG_PROCESS_ID = 8'h0C;
  localparam logic [7:0] ICBP_REG_STATUS = 8'h10;
  localparam logic [7:0] ICBP_REG_LOCK_COUNT = 8'h14;
  // control register fields
  localparam int ICBP_CTRL_BP_ENABLE_BIT = 11;
  localparam int ICBP_CTRL_IC_ENABLE_BIT = 12;
  // cache function codes, decoded from the low five bits (line offset) of the cache function register
  localparam logic [7:0] ICBP_FN_INVALIDATE_ALL = 8'h01;
  localparam logic [7:0] ICBP_FN_INVALIDATE_LINE = 8'h02;
  localparam logic [7:0] ICBP_FN_INVALIDATE_PREDICTOR = 8'h03;
  // lock function codes, low five bits (line offset) of the lock function register
  localparam logic [7:0] ICBP_FN_LOCK_LINE = 8'h01;
  localparam logic [7:0] ICBP_FN_UNLOCK_ALL = 8'h02;
  // ---------------------------------------------------------------
  // cache geometry
  // ---------------------------------------------------------------
  localparam int ICBP_WAYS = 32;
  localparam int ICBP_WAY_W = 5;
  localparam int ICBP_LINE_OFS_W = 5;
  localparam logic [4:0] ICBP_LAST_WAY = 5'h1F;
  localparam logic [4:0] ICBP_MAX_LOCKED = 5'h1C;
  // ---------------------------------------------------------------
  // predictor geometry and history
  // ---------------------------------------------------------------
  localparam int ICBP_BP_INDEX_LO = 2;
  localparam int ICBP_BP_INDEX_W = 7;
  localparam int ICBP_BP_TAG_LO = 9;
  localparam int ICBP_BP_TAG_W = 24;
  localparam int ICBP_TARGET_W = 31;
  typedef enum logic [1:0] {
    strongly_not_taken_state = 2'b00,
    weakly_not_taken_state = 2'b01,
    weakly_taken_state = 2'b10,
    strongly_taken_state = 2'b11
  } icbp_history_type;
endpackage : icbp_pkg

// [core/icbp_top.sv]
// How it works
// [R1] reset: cache off, nothing locked, all invalid
// [R2] control bit 12 enables instruction caching
// [R3] invalidate-all spares locked lines, clears buffers
// [R4] software syncs before relying on invalidate
// [R5] single-line invalidate selected by address; code drops every unlocked line of the addressed set
// [R6] at most 28 locks; ways 28-31 refused
// [R7] refused lock still allocates, pointer stays 31
// [R8] lock command fetches and locks given address
// [R9] software locks from uncached code, cache prepared
// [R10] locking routine 128 bytes from page edge
// [R11] locks fill way 0 upward to 27
// [R12] global unlock keeps lines valid, round-robin again
// [R13] unlock before invalidate to clear locked lines
// [R14] predictor: 128-entry direct-mapped store
// [R15] entry: tag, target, history, valid
// [R16] index bits 8:2, tag bits 31:9,1
// [R17] taken hit supplies stored target as fetch
// [R18] target 31 bits for halfword alignment
// [R19] history updated on every executed held branch
// [R20] new taken branch entry weakly taken, evicts
// [R21] reset: predictor disabled, all entries invalid
// [R22] cache invalidation also clears predictor
// [R23] pointer starts at 31, wraps past locked ways
// [R24] process id write clears predictor
// [R25] history is two-bit saturating counter
//
// Purpose: instruction cache control state and branch predictor store
// Assumes: fill path outside reports each completed line fill with its address and cacheability
// Notes: lock fetch is requested on lock_fetch_req and completes through the fill report
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/100ps
module icbp_top
  import icbp_pkg::*;
#(
  parameter int SETS = 32, // number of cache sets
  parameter int SET_W = 5, // set index width
  parameter int BP_ENTRIES = 128 // predictor entries
) (
  input wire logic clock, // core clock, 25 MHz
  input wire logic nrst, // synchronous reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic fill_done, // fill path wrote a line this cycle request
  input wire logic [31:0] fill_addr, // virtual address of filled line
  input wire logic fill_cacheable, // filled line is cacheable
  output logic ic_enable, // instruction caching enabled
  output logic fetch_buf_flush, // pulse: drop both fetch buffers
  output logic lock_fetch_req, // level: fetch line for locking
  output logic [31:0] lock_fetch_addr, // line address to fetch for locking
  output logic fill_write, // pulse: line written into cache
  output logic [SET_W-1:0] fill_set, // set written
  output logic [ICBP_WAY_W-1:0] fill_way, // way written
  input wire logic [31:0] fetch_addr, // current fetch address
  output logic predict_taken, // predictor redirects next fetch
  output logic [31:0] predict_target, // predicted next fetch address
  input wire logic br_valid, // branch resolved this cycle
  input wire logic [31:0] br_addr, // branch instruction address
  input wire logic [31:0] br_target, // branch target address
  input wire logic br_taken // branch outcome
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [SETS-1:0][ICBP_WAYS-1:0] line_valid;
  logic [SETS-1:0][ICBP_WAYS-1:0] line_locked;
  logic [ICBP_WAY_W-1:0] rr_ptr [SETS];
  logic [ICBP_WAY_W-1:0] lock_count [SETS];
  logic [31:0] control;
  logic [31:0] process_id;
  logic lock_pending;
  logic lock_refused;
  logic bp_valid [BP_ENTRIES];
  logic [ICBP_BP_TAG_W-1:0] bp_tag [BP_ENTRIES];
  logic [ICBP_TARGET_W-1:0] bp_target [BP_ENTRIES];
  icbp_history_type bp_hist [BP_ENTRIES];

  logic wb_req;
  logic wr_req;
  logic cmd_inval_all;
  logic cmd_inval_line;
  logic cmd_inval_bp;
  logic cmd_lock;
  logic cmd_unlock;
  logic pid_write;
  logic bp_flush;
  logic bp_enable;
  logic [SET_W-1:0] f_set;
  logic [SET_W-1:0] inv_set;
  logic [ICBP_LINE_OFS_W-1:0] fn_code;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_req = wb_req && wb_we_i && wb_sel_i[0];
  // function codes sit in the line offset bits, so the set index and the
  // lock address above them stay free for any set
  assign fn_code = wb_dat_i[ICBP_LINE_OFS_W-1:0];
  assign cmd_inval_all = wr_req && wb_adr_i == ICBP_REG_CACHE_FN
    && fn_code == ICBP_FN_INVALIDATE_ALL[ICBP_LINE_OFS_W-1:0];
  assign cmd_inval_line = wr_req && wb_adr_i == ICBP_REG_CACHE_FN
    && fn_code == ICBP_FN_INVALIDATE_LINE[ICBP_LINE_OFS_W-1:0];
  assign cmd_inval_bp = wr_req && wb_adr_i == ICBP_REG_CACHE_FN
    && fn_code == ICBP_FN_INVALIDATE_PREDICTOR[ICBP_LINE_OFS_W-1:0];
  assign cmd_lock = wr_req && wb_adr_i == ICBP_REG_LOCK_FN
    && fn_code == ICBP_FN_LOCK_LINE[ICBP_LINE_OFS_W-1:0] && !lock_pending;
  assign cmd_unlock = wr_req && wb_adr_i == ICBP_REG_LOCK_FN
    && fn_code == ICBP_FN_UNLOCK_ALL[ICBP_LINE_OFS_W-1:0];
  assign pid_write = wr_req && wb_adr_i == ICBP_REG_PROCESS_ID;
  // [R22] [R24] flush on cache invalidates
  assign bp_flush = cmd_inval_all || cmd_inval_line || cmd_inval_bp || pid_write;
  assign bp_enable = control[ICBP_CTRL_BP_ENABLE_BIT];
  assign f_set = fill_addr[ICBP_LINE_OFS_W +: SET_W];
  assign inv_set = wb_dat_i[ICBP_LINE_OFS_W +: SET_W];

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  // lock address is carried in the write data of the lock command
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i)
      begin
        unique case (wb_adr_i)
          // valid and locked masks of the set named in the write data
          ICBP_REG_CACHE_FN: wb_dat_o <= line_valid[inv_set];
          ICBP_REG_LOCK_FN: wb_dat_o <= line_locked[inv_set];
          ICBP_REG_CONTROL: wb_dat_o <= control;
          ICBP_REG_PROCESS_ID: wb_dat_o <= process_id;
          ICBP_REG_STATUS: wb_dat_o <= {30'h0, lock_refused, lock_pending};
          ICBP_REG_LOCK_COUNT: wb_dat_o <= {27'h0, lock_count[inv_set]};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // control and process id
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      // [R1] [R21] caching and prediction off
      control <= '0;
      process_id <= '0;
      ic_enable <= 1'b0;
    end
    else
    begin
      if (wb_req && wb_we_i && wb_adr_i == ICBP_REG_CONTROL)
      begin
        for (int b = 0; b < 4; b++)
          if (wb_sel_i[b])
            control[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
      end
      if (wb_req && wb_we_i && wb_adr_i == ICBP_REG_PROCESS_ID)
      begin
        for (int b = 0; b < 4; b++)
          if (wb_sel_i[b])
            process_id[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
      end
      // [R2] enable follows bit 12
      // written value is taken at once, so caching starts right after the write
      ic_enable <= (wb_req && wb_we_i && wb_adr_i == ICBP_REG_CONTROL && wb_sel_i[1])
        ? wb_dat_i[ICBP_CTRL_IC_ENABLE_BIT] : control[ICBP_CTRL_IC_ENABLE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // lock request
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      lock_pending <= 1'b0;
      lock_fetch_req <= 1'b0;
      lock_fetch_addr <= '0;
    end
    else
    begin
      // [R8] fetch the addressed line for locking
      // a lock met while one is in flight is dropped; status shows pending
      if (cmd_lock)
      begin
        lock_pending <= 1'b1;
        lock_fetch_req <= 1'b1;
        lock_fetch_addr <= {wb_dat_i[31:ICBP_LINE_OFS_W], {ICBP_LINE_OFS_W{1'b0}}};
      end
      else if (fill_done && lock_pending)
      begin
        lock_pending <= 1'b0;
        lock_fetch_req <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // line state per set
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      fill_write <= 1'b0;
      fill_set <= '0;
      fill_way <= '0;
      lock_refused <= 1'b0;
      fetch_buf_flush <= 1'b0;
    end
    else
    begin
      // [R3] fetch buffers dropped with whole invalidate
      fetch_buf_flush <= cmd_inval_all;
      fill_write <= 1'b0;
      if (fill_done && fill_cacheable && (ic_enable || lock_pending))
      begin
        fill_write <= 1'b1;
        fill_set <= f_set;
        // [R11] locked lines fill from way 0
        // fill_way must name the way that the set logic marks valid
        if (lock_pending && lock_count[f_set] < ICBP_MAX_LOCKED)
          fill_way <= lock_count[f_set];
        else
          fill_way <= rr_ptr[f_set];
        // [R6] refused when set already full
        lock_refused <= lock_pending && lock_count[f_set] >= ICBP_MAX_LOCKED;
      end
    end
  end

  for (genvar s = 0; s < SETS; s++)
  begin : g_set
    logic hit_fill;
    logic do_lock;
    assign hit_fill = fill_done && fill_cacheable && (ic_enable || lock_pending)
      && f_set == SET_W'(s);
    assign do_lock = hit_fill && lock_pending && lock_count[s] < ICBP_MAX_LOCKED;
    always_ff @(posedge clock)
    begin
      if (!nrst)
      begin
        // [R1] [R23] invalid, unlocked, pointer at 31
        line_valid[s] <= '0;
        line_locked[s] <= '0;
        lock_count[s] <= '0;
        rr_ptr[s] <= ICBP_LAST_WAY;
      end
      else
      begin
        // [R3] whole invalidate keeps locked lines
        if (cmd_inval_all)
          line_valid[s] <= line_valid[s] & line_locked[s];
        // [R5] all unlocked lines of the addressed set dropped
        else if (cmd_inval_line && inv_set == SET_W'(s))
          line_valid[s] <= '0 | (line_valid[s] & line_locked[s]);
        // [R12] unlock keeps lines valid
        if (cmd_unlock)
        begin
          line_locked[s] <= '0;
          lock_count[s] <= '0;
        end
        else if (do_lock)
        begin
          line_locked[s][lock_count[s]] <= 1'b1;
          lock_count[s] <= lock_count[s] + 1'b1;
        end
        // a lock fill that meets an unlock still lands, unlocked, so the
        // valid mask always agrees with fill_write
        if (do_lock)
        begin
          line_valid[s][lock_count[s]] <= 1'b1;
          if (rr_ptr[s] <= lock_count[s])
            rr_ptr[s] <= lock_count[s] + 1'b1;
        end
        else if (hit_fill)
        begin
          // [R7] refused lock allocates unlocked
          line_valid[s][rr_ptr[s]] <= 1'b1;
          // [R23] wrap to first unlocked way below 28, else stay at 31
          if (rr_ptr[s] == ICBP_LAST_WAY)
            rr_ptr[s] <= (lock_count[s] >= ICBP_MAX_LOCKED) ? ICBP_LAST_WAY : lock_count[s];
          else
            rr_ptr[s] <= rr_ptr[s] + 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // branch predictor store
  // ---------------------------------------------------------------
  // [R14] [R16] direct-mapped lookup
  logic [ICBP_BP_INDEX_W-1:0] f_idx;
  logic [ICBP_BP_INDEX_W-1:0] b_idx;
  logic [ICBP_BP_TAG_W-1:0] f_tag;
  logic [ICBP_BP_TAG_W-1:0] b_tag;
  logic f_hit;
  logic b_hit;
  assign f_idx = fetch_addr[ICBP_BP_INDEX_LO +: ICBP_BP_INDEX_W];
  assign b_idx = br_addr[ICBP_BP_INDEX_LO +: ICBP_BP_INDEX_W];
  assign f_tag = {fetch_addr[31:ICBP_BP_TAG_LO], fetch_addr[1]};
  assign b_tag = {br_addr[31:ICBP_BP_TAG_LO], br_addr[1]};
  assign f_hit = bp_valid[f_idx] && bp_tag[f_idx] == f_tag;
  assign b_hit = bp_valid[b_idx] && bp_tag[b_idx] == b_tag;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      predict_taken <= 1'b0;
      predict_target <= '0;
    end
    else
    begin
      // [R17] [R25] taken states redirect fetch
      predict_taken <= bp_enable && f_hit && bp_hist[f_idx][1];
      // [R18] halfword target, bit 0 zero
      predict_target <= {bp_target[f_idx], 1'b0};
    end
  end

  for (genvar e = 0; e < BP_ENTRIES; e++)
  begin : g_entry
    always_ff @(posedge clock)
    begin
      if (!nrst)
      begin
        // [R21] all entries invalid
        bp_valid[e] <= 1'b0;
        bp_tag[e] <= '0;
        bp_target[e] <= '0;
        bp_hist[e] <= weakly_taken_state;
      end
      // a flush wins over a branch update in the same cycle
      else if (bp_flush)
        bp_valid[e] <= 1'b0;
      else if (br_valid && bp_enable && b_idx == ICBP_BP_INDEX_W'(e))
      begin
        if (b_hit)
        begin
          // [R19] [R25] saturating history update
          if (br_taken && bp_hist[e] != strongly_taken_state)
            bp_hist[e] <= icbp_history_type'(bp_hist[e] + 2'b01);
          else if (!br_taken && bp_hist[e] != strongly_not_taken_state)
            bp_hist[e] <= icbp_history_type'(bp_hist[e] - 2'b01);
        end
        else if (br_taken)
        begin
          // [R15] [R20] new entry weakly taken
          bp_valid[e] <= 1'b1;
          bp_tag[e] <= b_tag;
          bp_target[e] <= br_target[31:1];
          bp_hist[e] <= weakly_taken_state;
        end
      end
    end
  end
endmodule : icbp_top

// [bench/icbp_monitor.sv]
// Purpose: port checker for icbp_top
// Assumes: one clock, nrst synchronous active low
// Notes: bound onto every icbp_top instance
`timescale 1ns/100ps
module icbp_monitor
  import icbp_pkg::*;
(
  input wire logic clock, // core clock
  input wire logic nrst, // reset, active low
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [7:0] wb_adr_i, // address
  input wire logic [3:0] wb_sel_i, // lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic wb_ack_o, // acknowledge
  input wire logic fill_done, // line complete
  input wire logic ic_enable, // caching on
  input wire logic fetch_buf_flush, // buffer drop
  input wire logic lock_fetch_req, // lock fetch
  input wire logic fill_write, // line written
  input wire logic [4:0] fill_way, // way written
  input wire logic predict_taken, // redirect
  input wire logic [31:0] predict_target // redirect address
);
  // ---------------------------------------------------------------
  // port relations
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  logic wr;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_cache_enable:
    assert property (wr && wb_adr_i == ICBP_REG_CONTROL && wb_sel_i[1]
      |=> ic_enable == $past(wb_dat_i[12])) else $error("cache enable wrong");
  a_buf_flush:
    assert property (wr && wb_adr_i == ICBP_REG_CACHE_FN && wb_sel_i[0]
      && wb_dat_i[7:0] == ICBP_FN_INVALIDATE_ALL |-> ##[0:1] fetch_buf_flush)
    else $error("no buffer flush");
  a_flush_pulse: assert property (fetch_buf_flush |=> !fetch_buf_flush)
    else $error("flush longer than a pulse");
  a_lock_hold: assert property (lock_fetch_req && !fill_done |=> lock_fetch_req)
    else $error("lock fetch dropped early");
  a_lock_fill: assert property (lock_fetch_req && fill_done |=> fill_write && !lock_fetch_req)
    else $error("lock fetch not written");
  a_fill_cause: assert property (fill_write |-> $past(fill_done))
    else $error("line written without fill");
  a_lock_way:
    assert property (fill_write && $past(lock_fetch_req)
      |-> fill_way < ICBP_MAX_LOCKED || fill_way == ICBP_LAST_WAY) else $error("lock way");
  a_reset_quiet:
    assert property (@(posedge clock) disable iff (1'b0) !nrst
      |=> !ic_enable && !predict_taken && !lock_fetch_req && !fill_write)
    else $error("outputs active after reset");
  a_target_half: assert property (predict_taken |-> !predict_target[0])
    else $error("target odd");
  c_lock: cover property (lock_fetch_req && fill_done);
  c_flush: cover property (fetch_buf_flush);
  c_predict: cover property (predict_taken);
endmodule : icbp_monitor

bind icbp_top icbp_monitor u_icbp_monitor (.clock, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .fill_done, .ic_enable, .fetch_buf_flush,
  .lock_fetch_req, .fill_write, .fill_way, .predict_taken, .predict_target);

// [bench/icbp_fill_model.sv]
// Purpose: fill path stand-in for lock fetches and plain fills
// Assumes: lock_fetch_req holds until fill_done is seen
// Notes: idle lines show the inverse of their last value
`timescale 1ns/100ps
module icbp_fill_model
(
  input wire logic clock, // core clock
  input wire logic nrst, // reset, active low
  input wire logic lock_fetch_req, // lock fetch wanted
  input wire logic [31:0] lock_fetch_addr, // line to fetch
  input wire logic req_go, // plain fill request
  input wire logic [31:0] req_addr, // plain fill address
  input wire logic req_cache, // plain fill cacheable
  input wire logic [3:0] lat, // lock fetch latency
  output logic fill_done, // line complete
  output logic [31:0] fill_addr, // line address
  output logic fill_cacheable // line cacheable
);
  logic [3:0] wait_cnt;
  // ---------------------------------------------------------------
  // fill sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      fill_done <= 1'b0;
      fill_addr <= 32'h0;
      fill_cacheable <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if (fill_done)
    begin
      fill_done <= 1'b0;
      fill_addr <= ~fill_addr;
      fill_cacheable <= ~fill_cacheable;
    end
    else if (req_go)
    begin
      fill_done <= 1'b1;
      fill_addr <= req_addr;
      fill_cacheable <= req_cache;
    end
    // locked code comes back whole and cacheable
    else if (lock_fetch_req && wait_cnt == lat)
    begin
      fill_done <= 1'b1;
      fill_addr <= lock_fetch_addr;
      fill_cacheable <= 1'b1;
      wait_cnt <= 4'h0;
    end
    else if (lock_fetch_req)
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule : icbp_fill_model

// [bench/icbp_top_test.sv]
// Purpose: self-checking bench for icbp_top
// Assumes: one-cycle Wishbone ack, fill model on the far side
// Notes: expectations follow the cache and predictor rules
`timescale 1ns/100ps
module icbp_top_test
  import icbp_pkg::*;
;
  logic clock, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fill_done, fill_cacheable;
  logic ic_enable, fetch_buf_flush, lock_fetch_req, fill_write, predict_taken;
  logic br_valid, br_taken, req_go, req_cache;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, lat;
  logic [4:0] fill_set, fill_way;
  logic [31:0] wb_dat_i, wb_dat_o, fill_addr, lock_fetch_addr, fetch_addr, predict_target;
  logic [31:0] br_addr, br_target, req_addr, rd;
  int error_cnt, checked;
  icbp_top u_icbp_top (.clock, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .fill_done, .fill_addr, .fill_cacheable, .ic_enable,
    .fetch_buf_flush, .lock_fetch_req, .lock_fetch_addr, .fill_write, .fill_set, .fill_way,
    .fetch_addr, .predict_taken, .predict_target, .br_valid, .br_addr, .br_target, .br_taken);
  icbp_fill_model u_icbp_fill_model (.clock, .nrst, .lock_fetch_req, .lock_fetch_addr,
    .req_go, .req_addr, .req_cache, .lat, .fill_done, .fill_addr, .fill_cacheable);
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clock);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    chk("wishbone ack", 32'h1, {31'h0, wb_ack_o});
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : xfer
  // a zero expectation means no line may be written
  task automatic fill_wait(input logic [10:0] exp);
    int n;
    n = 0;
    while (fill_write !== 1'b1 && n < 24)
    begin
      @(negedge clock);
      n++;
    end
    chk("fill set way", {21'h0, exp}, {21'h0, fill_write ? {1'b1, fill_set, fill_way} : 11'h0});
  endtask : fill_wait
  task automatic fill(input logic [31:0] a, input logic c, input logic [10:0] exp);
    @(posedge clock);
    req_go <= 1'b1;
    req_addr <= a;
    req_cache <= c;
    @(posedge clock);
    req_go <= 1'b0;
    fill_wait(exp);
  endtask : fill
  task automatic lock(input logic [31:0] a, input logic [10:0] exp);
    xfer(1'b1, ICBP_REG_LOCK_FN, a | 32'h1);
    @(negedge clock);
    chk("lock address", a, lock_fetch_addr);
    fill_wait(exp);
  endtask : lock
  task automatic cnt(input logic [4:0] set, input logic [31:0] exp);
    xfer(1'b0, ICBP_REG_LOCK_COUNT, {22'h0, set, 5'h0});
    chk("lock count", exp, rd);
  endtask : cnt
  task automatic lines(input logic [4:0] set, input logic [31:0] exp);
    xfer(1'b0, ICBP_REG_CACHE_FN, {22'h0, set, 5'h0});
    chk("valid lines", exp, rd);
  endtask : lines
  task automatic branch(input logic [31:0] a, input logic [31:0] t, input logic tk);
    @(posedge clock);
    br_valid <= 1'b1;
    br_addr <= a;
    br_target <= t;
    br_taken <= tk;
    @(posedge clock);
    br_valid <= 1'b0;
  endtask : branch
  task automatic probe(input logic [31:0] a, input logic hit, input logic [31:0] t);
    @(posedge clock);
    fetch_addr <= a;
    @(posedge clock);
    @(negedge clock);
    chk("predict hit", {31'h0, hit}, {31'h0, predict_taken});
    if (hit)
      chk("predict target", t, predict_target);
  endtask : probe
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial
  begin
    #200000;
    error_cnt++;
    stop_test();
  end
  initial
  begin
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i, br_valid, br_taken, req_go, req_cache} = 8'h0;
    {wb_adr_i, wb_dat_i, br_addr, br_target, req_addr, fetch_addr} = 168'h0;
    wb_sel_i = 4'hF;
    lat = 4'h0;
    error_cnt = 0;
    checked = 0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    cnt(5'h3, 32'h0);
    chk("cache enable", 32'h0, {31'h0, ic_enable});
    fill(32'h40, 1'b1, 11'h0);
    xfer(1'b1, ICBP_REG_CONTROL, 32'h1000);
    @(negedge clock);
    chk("cache enable", 32'h1, {31'h0, ic_enable});
    branch(32'h1230, 32'h4566, 1'b1);
    probe(32'h1230, 1'b0, 32'h0);
    xfer(1'b1, ICBP_REG_CONTROL, 32'h1800);
    fill(32'h40, 1'b1, {1'b1, 5'h2, 5'h1F});
    fill(32'h40, 1'b1, {1'b1, 5'h2, 5'h0});
    fill(32'h40, 1'b0, 11'h0);
    for (int k = 0; k < 28; k++)
    begin
      lat <= k[0] ? 4'h3 : 4'h0;
      lock(32'h60 + k * 32'h400, {1'b1, 5'h3, k[4:0]});
    end
    cnt(5'h3, 32'd28);
    lock(32'h8060, {1'b1, 5'h3, 5'h1F});
    cnt(5'h3, 32'd28);
    lines(5'h3, 32'h8FFFFFFF);
    xfer(1'b0, ICBP_REG_STATUS, 32'h0);
    chk("lock refused", 32'h2, rd);
    xfer(1'b1, ICBP_REG_CACHE_FN, 32'h1);
    cnt(5'h3, 32'd28);
    lines(5'h3, 32'h0FFFFFFF);
    lines(5'h2, 32'h0);
    xfer(1'b1, ICBP_REG_LOCK_FN, 32'h2);
    cnt(5'h3, 32'h0);
    lines(5'h3, 32'h0FFFFFFF);
    xfer(1'b1, ICBP_REG_CACHE_FN, 32'h1);
    lines(5'h3, 32'h0);
    lock(32'h60, {1'b1, 5'h3, 5'h0});
    fill(32'h40, 1'b1, {1'b1, 5'h2, 5'h1});
    xfer(1'b1, ICBP_REG_CACHE_FN, 32'h62);
    lines(5'h3, 32'h1);
    lines(5'h2, 32'h2);
    branch(32'h1230, 32'h4566, 1'b1);
    probe(32'h1230, 1'b1, 32'h4566);
    probe(32'h1232, 1'b0, 32'h0);
    probe(32'h1430, 1'b0, 32'h0);
    branch(32'h1230, 32'h4566, 1'b0);
    probe(32'h1230, 1'b0, 32'h0);
    branch(32'h1230, 32'h4566, 1'b1);
    branch(32'h1230, 32'h4566, 1'b1);
    branch(32'h1230, 32'h4566, 1'b0);
    probe(32'h1230, 1'b1, 32'h4566);
    branch(32'h1230, 32'h4566, 1'b0);
    branch(32'h1230, 32'h4566, 1'b0);
    branch(32'h1230, 32'h4566, 1'b1);
    probe(32'h1230, 1'b0, 32'h0);
    branch(32'h1430, 32'h8000, 1'b1);
    probe(32'h1230, 1'b0, 32'h0);
    probe(32'h1430, 1'b1, 32'h8000);
    xfer(1'b1, ICBP_REG_PROCESS_ID, 32'h5);
    probe(32'h1430, 1'b0, 32'h0);
    branch(32'h1230, 32'h4566, 1'b1);
    xfer(1'b1, ICBP_REG_CACHE_FN, 32'h1);
    probe(32'h1230, 1'b0, 32'h0);
    branch(32'h1230, 32'h4566, 1'b1);
    xfer(1'b1, ICBP_REG_CACHE_FN, 32'h3);
    probe(32'h1230, 1'b0, 32'h0);
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    lines(5'h3, 32'h0);
    cnt(5'h3, 32'h0);
    chk("cache enable", 32'h0, {31'h0, ic_enable});
    branch(32'h1230, 32'h4566, 1'b1);
    probe(32'h1230, 1'b0, 32'h0);
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, rd);
    stop_test();
  end
endmodule : icbp_top_test
